// [design/pld_regs.vh]
// Purpose: Offsets, field positions, reset values and constants of the
//          logical device configuration bank.
// Assumes: Included by its bare name from every design file.
// Notes:   Definitions only.
`ifndef PLD_REGS_VH
`define PLD_REGS_VH

// Card-level control offsets
`define PLD_OFS_CFG_CTRL   8'h02
`define PLD_OFS_LDN        8'h07

// Per logical device offsets
`define PLD_OFS_ACTIVATE   8'h30
`define PLD_OFS_RANGE_CHK  8'h31
`define PLD_OFS_BASE0_HI   8'h60
`define PLD_OFS_BASE0_LO   8'h61
`define PLD_OFS_BASE1_HI   8'h62
`define PLD_OFS_BASE1_LO   8'h63
`define PLD_OFS_IRQ_LEVEL  8'h70
`define PLD_OFS_IRQ_TYPE   8'h71
`define PLD_OFS_DMA_FIRST  8'h74
`define PLD_OFS_DMA_SECOND 8'h75

// Field positions
`define PLD_BIT_ACTIVATE   0
`define PLD_BIT_RC_PAT     0
`define PLD_BIT_RC_EN      1
`define PLD_BIT_CFG_RST    0
`define PLD_BIT_HDR_MIDI   0
`define PLD_BIT_HDR_CD     1
`define PLD_BIT_HDR_MODEM  2

// Fixed readbacks and reset values
`define PLD_IRQ_TYPE_VAL   8'h02
`define PLD_DMA_NONE_VAL   8'h04
`define PLD_PAT_ZERO       8'haa
`define PLD_PAT_ONE        8'h55
`define PLD_RST_BYTE       8'h00
`define PLD_RST_BASE       12'h000

// Logical device numbers
`define PLD_LDN_JOY        8'h02
`define PLD_LDN_FIRST_OPT  8'h03

// Decoder sizes
`define PLD_SIZE_JOY       13'h0001
`define PLD_SIZE_MIDI      13'h0002
`define PLD_SIZE_CD0       13'h0008
`define PLD_SIZE_CD1       13'h0004
`define PLD_SIZE_MODEM     13'h0008

// Header capture: edge count after release at which straps are taken
`define PLD_HDR_LOAD_CNT   2'h2

`endif

// [design/pld_range_dec.v]
// Purpose: One I/O address range decoder.
// Assumes: Base and address are 12-bit ISA I/O addresses.
// Notes:   Purely combinational; a zero base never claims anything.
`include "pld_regs.vh"

module pld_range_dec #(
  parameter [12:0] SIZE = `PLD_SIZE_JOY  // Locations claimed
) (
  input  wire [11:0] base,               // Programmed base
  input  wire [11:0] addr,               // Host I/O address
  output wire        hit                 // Address inside range
);

  wire [12:0] lo_ext;                    // Base widened for carry
  wire [12:0] hi_ext;                    // First location past range
  wire [12:0] ad_ext;                    // Address widened

  assign lo_ext = {1'b0, base};
  assign hi_ext = lo_ext + SIZE;
  assign ad_ext = {1'b0, addr};

  // Zero base disables; range is base up to base plus size minus one
  assign hit = (base != `PLD_RST_BASE) && (ad_ext >= lo_ext) &&
               (ad_ext < hi_ext);

endmodule

// [design/pld_ldev.v]
// Purpose: Register set of one logical device.
// Assumes: Writes reach it only while its device number is selected.
// Notes:   Optional second base pair and interrupt level by parameter.
`include "pld_regs.vh"

module pld_ldev #(
  parameter HAS_IRQ   = 1,               // Interrupt level register
  parameter HAS_BASE1 = 0                // Second base pair
) (
  input  wire        clk,                // System clock
  input  wire        rst_n,              // Synchronous reset, low
  input  wire        cfg_rst,            // Card configuration reset
  input  wire        sel,                // Device number selected
  input  wire        wr,                 // Register write strobe
  input  wire [7:0]  addr,               // Register offset
  input  wire [7:0]  wdata,              // Write data
  output reg  [7:0]  rd_val,             // Read value at addr
  output wire        act,                // Activate bit
  output wire        rc_en,              // Range check enable
  output wire        rc_pat,             // Range check pattern
  output wire [11:0] base0,              // Decoder 0 base
  output wire [11:0] base1,              // Decoder 1 base
  output wire [7:0]  irq                 // Interrupt level
);

  reg        act_reg;                    // Activate
  reg  [1:0] rc_reg;                     // Range check control
  reg  [3:0] b0h_reg;                    // Base 0 bits 11:8
  reg  [7:0] b0l_reg;                    // Base 0 bits 7:0
  reg  [3:0] b1h_reg;                    // Base 1 bits 11:8
  reg  [7:0] b1l_reg;                    // Base 1 bits 7:0
  reg  [7:0] irq_reg;                    // Interrupt level
  wire       we;                         // Write to this device

  assign we = wr & sel;

  // Register writes; config reset clears only the activate bit
  always @(posedge clk) begin
    if (!rst_n) begin
      act_reg <= 1'b0;
      rc_reg  <= 2'h0;
      b0h_reg <= 4'h0;
      b0l_reg <= `PLD_RST_BYTE;
      b1h_reg <= 4'h0;
      b1l_reg <= `PLD_RST_BYTE;
      irq_reg <= `PLD_RST_BYTE;
    end else begin
      if (cfg_rst)
        act_reg <= 1'b0;
      else if (we && addr == `PLD_OFS_ACTIVATE)
        act_reg <= wdata[`PLD_BIT_ACTIVATE];
      if (we && addr == `PLD_OFS_RANGE_CHK)
        rc_reg <= wdata[1:0];
      if (we && addr == `PLD_OFS_BASE0_HI)
        b0h_reg <= wdata[3:0];
      if (we && addr == `PLD_OFS_BASE0_LO)
        b0l_reg <= wdata;
      if (HAS_BASE1 != 0 && we && addr == `PLD_OFS_BASE1_HI)
        b1h_reg <= wdata[3:0];
      if (HAS_BASE1 != 0 && we && addr == `PLD_OFS_BASE1_LO)
        b1l_reg <= wdata;
      if (HAS_IRQ != 0 && we && addr == `PLD_OFS_IRQ_LEVEL)
        irq_reg <= wdata;
    end
  end

  // Readback; reserved bits and absent registers read zero
  always @* begin
    rd_val = `PLD_RST_BYTE;
    case (addr)
      `PLD_OFS_ACTIVATE:   rd_val = {7'h00, act_reg};
      `PLD_OFS_RANGE_CHK:  rd_val = {6'h00, rc_reg};
      `PLD_OFS_BASE0_HI:   rd_val = {4'h0, b0h_reg};
      `PLD_OFS_BASE0_LO:   rd_val = b0l_reg;
      `PLD_OFS_BASE1_HI:   rd_val = {4'h0, b1h_reg};
      `PLD_OFS_BASE1_LO:   rd_val = b1l_reg;
      `PLD_OFS_IRQ_LEVEL:  rd_val = irq_reg;
      `PLD_OFS_IRQ_TYPE:
        rd_val = (HAS_IRQ != 0) ? `PLD_IRQ_TYPE_VAL : `PLD_RST_BYTE;
      `PLD_OFS_DMA_FIRST:  rd_val = `PLD_DMA_NONE_VAL;
      `PLD_OFS_DMA_SECOND: rd_val = `PLD_DMA_NONE_VAL;
      default:             rd_val = `PLD_RST_BYTE;
    endcase
  end

  assign act    = act_reg;
  assign rc_en  = rc_reg[`PLD_BIT_RC_EN];
  assign rc_pat = rc_reg[`PLD_BIT_RC_PAT];
  assign base0  = {b0h_reg, b0l_reg};
  assign base1  = (HAS_BASE1 != 0) ? {b1h_reg, b1l_reg} : `PLD_RST_BASE;
  assign irq    = (HAS_IRQ != 0) ? irq_reg : `PLD_RST_BYTE;

endmodule

// [design/pld_top.v]
// Purpose: Configuration bank for the joystick, MIDI UART, CD-ROM and
//          modem logical devices, with their I/O range decoders.
// Assumes: Config port and host I/O strobes are on CLK_SYS; the three
//          presence straps are asynchronous pins.
// Notes:   Decoder selects and range check answers lag the I/O strobe
//          by one cycle so every output comes from a flip-flop.
`include "pld_regs.vh"

// Operation
// - Activate bit zero, per logical device
// - Activate clears on reset and config reset
// - One activate register, chosen by device number
// - Range check bit one enables check
// - Range pattern bit selects AA or 55
// - Base high holds bits 11:8, low 7:0
// - Joystick claims one location, zero disables
// - MIDI claims two locations, zero disables
// - CD first range eight locations
// - CD second range four locations
// - Modem claims eight locations, zero disables
// - MIDI, CD, modem hold interrupt level
// - Interrupt type reads 2 on MIDI, CD, modem (0 on joystick), writes ignored
// - First DMA select reads 4
// - Second DMA select reads 4
// - CD optional, device number 3 or 4
// - Modem optional, device number 3-5
// - MIDI separate only when configured
// - CD presence follows header strap
// - MIDI strap places it at device 3
// - Modem presence follows header strap
module pld_top (
  input  wire        CLK_SYS,            // 20 MHz system clock
  input  wire        RST_N,              // Synchronous reset, low
  input  wire [7:0]  CFG_ADDR,           // Config register offset
  input  wire [7:0]  CFG_WDATA,          // Config write data
  input  wire        CFG_WR,             // Config write strobe
  input  wire        CFG_RD,             // Config read strobe
  output reg  [7:0]  CFG_RDATA,          // Read data, cycle after
  input  wire [2:0]  HDR_STRAP,          // Presence straps, async
  input  wire [11:0] IO_ADDR,            // Host I/O address
  input  wire        IO_RD,              // Host I/O read strobe
  input  wire        IO_WR,              // Host I/O write strobe
  output reg  [7:0]  IO_RDATA,           // Range check pattern
  output reg         IO_RVALID,          // Pattern answer valid
  output reg         JOY_CS,             // Joystick access
  output reg         MIDI_CS,            // MIDI UART access
  output reg         CD_CS0,             // CD first range access
  output reg         CD_CS1,             // CD second range access
  output reg         MODEM_CS,           // Modem access
  output reg  [2:0]  PRESENT,            // Latched presence straps
  output reg  [7:0]  MIDI_IRQ,           // MIDI interrupt level
  output reg  [7:0]  CD_IRQ,             // CD interrupt level
  output reg  [7:0]  MODEM_IRQ           // Modem interrupt level
);

  // Pattern byte for a range check select bit
  function [7:0] rc_byte;
    input pat;
    begin
      rc_byte = pat ? `PLD_PAT_ONE : `PLD_PAT_ZERO;
    end
  endfunction

  reg  [2:0]  hdr_s1_reg;                // Strap sync stage 1
  reg  [2:0]  hdr_s2_reg;                // Strap sync stage 2
  reg  [1:0]  load_cnt_reg;              // Edges since release
  reg  [2:0]  hdr_reg;                   // Latched straps
  reg  [7:0]  ldn_reg;                   // Selected device number
  reg         cfg_rst_reg;               // Config reset pulse
  reg  [7:0]  rd_next;                   // Config read mux
  reg  [7:0]  io_rdata_next;             // Pattern mux
  reg         io_rvalid_next;            // Pattern answer

  wire        midi_pres;                 // MIDI separate device
  wire        cd_pres;                   // CD device present
  wire        modem_pres;                // Modem device present
  wire [7:0]  midi_ldn;                  // MIDI device number
  wire [7:0]  cd_ldn;                    // CD device number
  wire [7:0]  modem_ldn;                 // Modem device number
  wire        sel_joy;                   // Device selects
  wire        sel_midi;
  wire        sel_cd;
  wire        sel_modem;
  wire        io_acc;                    // Any host I/O strobe

  // Per-device register outputs
  wire [7:0]  joy_rd, midi_rd, cd_rd, modem_rd;
  wire        joy_act, midi_act, cd_act, modem_act;
  wire        joy_rce, midi_rce, cd_rce, modem_rce;
  wire        joy_rcp, midi_rcp, cd_rcp, modem_rcp;
  wire [11:0] joy_b0, midi_b0, cd_b0, cd_b1, modem_b0;
  wire [7:0]  midi_irq, cd_irq, modem_irq;

  // Decoder hits
  wire        joy_hit, midi_hit, cd_hit0, cd_hit1, modem_hit;
  wire        cd_hit;

  // Straps cross through two flops before anything reads them
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      hdr_s1_reg <= 3'h0;
      hdr_s2_reg <= 3'h0;
    end else begin
      hdr_s1_reg <= HDR_STRAP;
      hdr_s2_reg <= hdr_s1_reg;
    end
  end

  // Capture straps once the sync chain holds the pin value after a
  // hardware or config reset; they stay fixed until the next one
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      load_cnt_reg <= 2'h0;
      hdr_reg      <= 3'h0;
    end else if (cfg_rst_reg) begin
      load_cnt_reg <= 2'h0;
    end else if (load_cnt_reg != 2'h3) begin
      load_cnt_reg <= load_cnt_reg + 2'h1;
      if (load_cnt_reg == `PLD_HDR_LOAD_CNT)
        hdr_reg <= hdr_s2_reg;
    end
  end

  assign midi_pres  = hdr_reg[`PLD_BIT_HDR_MIDI];
  assign cd_pres    = hdr_reg[`PLD_BIT_HDR_CD];
  assign modem_pres = hdr_reg[`PLD_BIT_HDR_MODEM];

  // Optional devices take the next free numbers from three upward
  assign midi_ldn  = `PLD_LDN_FIRST_OPT;
  assign cd_ldn    = `PLD_LDN_FIRST_OPT +
                     {7'h00, midi_pres};
  assign modem_ldn = `PLD_LDN_FIRST_OPT + {7'h00, midi_pres} +
                     {7'h00, cd_pres};

  // Absent devices never match, so their registers are unreachable
  assign sel_joy   = (ldn_reg == `PLD_LDN_JOY);
  assign sel_midi  = midi_pres  && (ldn_reg == midi_ldn);
  assign sel_cd    = cd_pres    && (ldn_reg == cd_ldn);
  assign sel_modem = modem_pres && (ldn_reg == modem_ldn);

  // Device number and config reset pulse
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ldn_reg     <= `PLD_RST_BYTE;
      cfg_rst_reg <= 1'b0;
    end else begin
      if (CFG_WR && CFG_ADDR == `PLD_OFS_LDN)
        ldn_reg <= CFG_WDATA;
      cfg_rst_reg <= CFG_WR && (CFG_ADDR == `PLD_OFS_CFG_CTRL) &&
                     CFG_WDATA[`PLD_BIT_CFG_RST];
    end
  end

  // Joystick: no interrupt, single base pair
  pld_ldev #(.HAS_IRQ(0), .HAS_BASE1(0)) u_joy (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .cfg_rst (cfg_rst_reg),
    .sel     (sel_joy),
    .wr      (CFG_WR),
    .addr    (CFG_ADDR),
    .wdata   (CFG_WDATA),
    .rd_val  (joy_rd),
    .act     (joy_act),
    .rc_en   (joy_rce),
    .rc_pat  (joy_rcp),
    .base0   (joy_b0),
    .base1   (),
    .irq     ()
  );

  // MIDI UART as its own device
  pld_ldev #(.HAS_IRQ(1), .HAS_BASE1(0)) u_midi (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .cfg_rst (cfg_rst_reg),
    .sel     (sel_midi),
    .wr      (CFG_WR),
    .addr    (CFG_ADDR),
    .wdata   (CFG_WDATA),
    .rd_val  (midi_rd),
    .act     (midi_act),
    .rc_en   (midi_rce),
    .rc_pat  (midi_rcp),
    .base0   (midi_b0),
    .base1   (),
    .irq     (midi_irq)
  );

  // CD-ROM interface with second base pair
  pld_ldev #(.HAS_IRQ(1), .HAS_BASE1(1)) u_cd (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .cfg_rst (cfg_rst_reg),
    .sel     (sel_cd),
    .wr      (CFG_WR),
    .addr    (CFG_ADDR),
    .wdata   (CFG_WDATA),
    .rd_val  (cd_rd),
    .act     (cd_act),
    .rc_en   (cd_rce),
    .rc_pat  (cd_rcp),
    .base0   (cd_b0),
    .base1   (cd_b1),
    .irq     (cd_irq)
  );

  // Modem
  pld_ldev #(.HAS_IRQ(1), .HAS_BASE1(0)) u_modem (
    .clk     (CLK_SYS),
    .rst_n   (RST_N),
    .cfg_rst (cfg_rst_reg),
    .sel     (sel_modem),
    .wr      (CFG_WR),
    .addr    (CFG_ADDR),
    .wdata   (CFG_WDATA),
    .rd_val  (modem_rd),
    .act     (modem_act),
    .rc_en   (modem_rce),
    .rc_pat  (modem_rcp),
    .base0   (modem_b0),
    .base1   (),
    .irq     (modem_irq)
  );

  // Address range decoders
  pld_range_dec #(.SIZE(`PLD_SIZE_JOY)) u_dec_joy (
    .base (joy_b0),
    .addr (IO_ADDR),
    .hit  (joy_hit)
  );

  pld_range_dec #(.SIZE(`PLD_SIZE_MIDI)) u_dec_midi (
    .base (midi_b0),
    .addr (IO_ADDR),
    .hit  (midi_hit)
  );

  pld_range_dec #(.SIZE(`PLD_SIZE_CD0)) u_dec_cd0 (
    .base (cd_b0),
    .addr (IO_ADDR),
    .hit  (cd_hit0)
  );

  pld_range_dec #(.SIZE(`PLD_SIZE_CD1)) u_dec_cd1 (
    .base (cd_b1),
    .addr (IO_ADDR),
    .hit  (cd_hit1)
  );

  pld_range_dec #(.SIZE(`PLD_SIZE_MODEM)) u_dec_modem (
    .base (modem_b0),
    .addr (IO_ADDR),
    .hit  (modem_hit)
  );

  assign cd_hit = cd_hit0 | cd_hit1;
  assign io_acc = IO_RD | IO_WR;

  // Config read mux; unmapped offsets and absent devices read zero
  always @* begin
    rd_next = `PLD_RST_BYTE;
    if (CFG_ADDR == `PLD_OFS_LDN)
      rd_next = ldn_reg;
    else if (sel_joy)
      rd_next = joy_rd;
    else if (sel_midi)
      rd_next = midi_rd;
    else if (sel_cd)
      rd_next = cd_rd;
    else if (sel_modem)
      rd_next = modem_rd;
  end

  // Range check answer; lowest device number wins an overlap, which
  // is exactly the conflict software is probing for
  always @* begin
    io_rdata_next  = `PLD_RST_BYTE;
    io_rvalid_next = 1'b0;
    if (IO_RD) begin
      if (joy_hit && joy_rce && !joy_act) begin
        io_rdata_next  = rc_byte(joy_rcp);
        io_rvalid_next = 1'b1;
      end else if (midi_pres && midi_hit && midi_rce && !midi_act) begin
        io_rdata_next  = rc_byte(midi_rcp);
        io_rvalid_next = 1'b1;
      end else if (cd_pres && cd_hit && cd_rce && !cd_act) begin
        io_rdata_next  = rc_byte(cd_rcp);
        io_rvalid_next = 1'b1;
      end else if (modem_pres && modem_hit && modem_rce &&
                   !modem_act) begin
        io_rdata_next  = rc_byte(modem_rcp);
        io_rvalid_next = 1'b1;
      end
    end
  end

  // Config read data stands only in the cycle after the strobe
  always @(posedge CLK_SYS) begin
    if (!RST_N)
      CFG_RDATA <= `PLD_RST_BYTE;
    else if (CFG_RD)
      CFG_RDATA <= rd_next;
    else
      CFG_RDATA <= `PLD_RST_BYTE;
  end

  // Registered decoder selects; only active devices claim cycles
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      JOY_CS   <= 1'b0;
      MIDI_CS  <= 1'b0;
      CD_CS0   <= 1'b0;
      CD_CS1   <= 1'b0;
      MODEM_CS <= 1'b0;
    end else begin
      JOY_CS   <= io_acc && joy_act && joy_hit;
      MIDI_CS  <= io_acc && midi_pres && midi_act && midi_hit;
      CD_CS0   <= io_acc && cd_pres && cd_act && cd_hit0;
      CD_CS1   <= io_acc && cd_pres && cd_act && cd_hit1;
      MODEM_CS <= io_acc && modem_pres && modem_act &&
                  modem_hit;
    end
  end

  // Range check answer and status outputs
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      IO_RDATA  <= `PLD_RST_BYTE;
      IO_RVALID <= 1'b0;
      PRESENT   <= 3'h0;
      MIDI_IRQ  <= `PLD_RST_BYTE;
      CD_IRQ    <= `PLD_RST_BYTE;
      MODEM_IRQ <= `PLD_RST_BYTE;
    end else begin
      IO_RDATA  <= io_rdata_next;
      IO_RVALID <= io_rvalid_next;
      PRESENT   <= hdr_reg;
      MIDI_IRQ  <= midi_irq;
      CD_IRQ    <= cd_irq;
      MODEM_IRQ <= modem_irq;
    end
  end

endmodule

// [verif/pld_top_monitor.sv]
// Purpose: Port checker for the logical device configuration bank.
// Assumes: One clock; reset synchronous and low.
// Notes:   Sees only the top ports; bound from the bench.
module pld_monitor (
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic       CFG_RD,
  input wire logic [7:0] CFG_RDATA,
  input wire logic       IO_RD,
  input wire logic       IO_WR,
  input wire logic       IO_RVALID,
  input wire logic [7:0] IO_RDATA,
  input wire logic       JOY_CS,
  input wire logic       MIDI_CS,
  input wire logic       CD_CS0,
  input wire logic       CD_CS1,
  input wire logic       MODEM_CS,
  input wire logic [2:0] PRESENT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // No host cycle taken at this edge
  sequence s_io_idle;
    !IO_RD && !IO_WR;
  endsequence
  // No config read taken at this edge
  sequence s_cfg_idle;
    !CFG_RD;
  endsequence

  AST_RDATA_IDLE: assert property (s_cfg_idle |=> CFG_RDATA == 8'h00)
    else $error("config read data outside its slot");
  AST_CS_QUIET: assert property (s_io_idle |=> !JOY_CS && !MIDI_CS
    && !CD_CS0 && !CD_CS1 && !MODEM_CS)
    else $error("select without a host cycle");
  AST_PAT_CAUSE: assert property (IO_RVALID |-> $past(IO_RD))
    else $error("pattern answer without a host read");
  AST_WR_NO_PAT: assert property (IO_WR |=> !IO_RVALID)
    else $error("pattern answer to a host write");
  AST_PAT_VALUE: assert property (IO_RVALID |->
    (IO_RDATA == 8'haa || IO_RDATA == 8'h55))
    else $error("pattern byte neither aa nor 55");
  AST_PAT_IDLE: assert property (!IO_RVALID |-> IO_RDATA == 8'h00)
    else $error("pattern data without valid");
  AST_MIDI_PRESENT: assert property (MIDI_CS |-> PRESENT[0])
    else $error("separate uart selected while absent");
  AST_CD_PRESENT: assert property ((CD_CS0 || CD_CS1) |-> PRESENT[1])
    else $error("cd selected while absent");
  AST_MODEM_PRESENT: assert property (MODEM_CS |-> PRESENT[2])
    else $error("modem selected while absent");
endmodule

// [verif/pld_host_model.sv]
// Purpose: Host model driving config and host I/O cycles.
// Assumes: Each task is entered just after a rising edge.
// Notes:   Released address and data lines show the inverse of their last value; strobes go low.
module pld_host_model (
  input  wire logic        clk,
  output logic [7:0]  cfg_addr,
  output logic [7:0]  cfg_wdata,
  output logic        cfg_wr,
  output logic        cfg_rd,
  output logic [11:0] io_addr,
  output logic        io_rd,
  output logic        io_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus from time zero
  initial begin
    {cfg_addr, cfg_wdata, cfg_wr, cfg_rd} = 18'h00000;
    {io_addr, io_rd, io_wr} = 14'h0000;
  end
  // One config cycle; strobe lasts one clock
  task automatic cfg(input bit r, input logic [7:0] a, input logic [7:0] d);
    cfg_addr  <= a;
    cfg_wdata <= d;
    cfg_wr    <= !r;
    cfg_rd    <= r;
    io_rd     <= 1'b0;
    io_wr     <= 1'b0;
    @(posedge clk);
  endtask
  // One host I/O cycle
  task automatic io(input bit r, input logic [11:0] a);
    io_addr <= a;
    io_rd   <= r;
    io_wr   <= !r;
    cfg_wr  <= 1'b0;
    cfg_rd  <= 1'b0;
    @(posedge clk);
  endtask
  // Release: no stale value left on the lines
  task automatic idle();
    {cfg_wr, cfg_rd, io_rd, io_wr} <= 4'h0;
    cfg_addr  <= ~cfg_addr;
    cfg_wdata <= ~cfg_wdata;
    io_addr   <= ~io_addr;
    @(posedge clk);
  endtask
endmodule

// [verif/pld_top_tb.sv]
// Purpose: Self-checking bench for the configuration bank.
// Assumes: Host model drives both ports; straps held per reset.
// Notes:   Every read and host I/O request notes its expected outputs in a queue.
module pld_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n, cfg_wr, cfg_rd, io_rd, io_wr, io_rvalid;
  logic [2:0]  strap, present;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, io_rdata, r;
  logic [7:0]  midi_irq, cd_irq, modem_irq;
  logic [11:0] io_addr;
  logic [4:0]  cs;                 // Joy, uart, cd0, cd1, modem
  logic [4:0]  exp_cs;             // Expected selects, same order
  logic [21:0] exp_q[$];           // Expected output notes
  logic [11:0] bases[4];
  logic [11:0] sizes[4];
  logic        pend;
  integer      failures, comparisons, cycles, seed, i;

  pld_host_model host (.clk(clk_sys), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr));
  pld_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CFG_ADDR(cfg_addr),
    .CFG_WDATA(cfg_wdata), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
    .CFG_RDATA(cfg_rdata), .HDR_STRAP(strap), .IO_ADDR(io_addr),
    .IO_RD(io_rd), .IO_WR(io_wr), .IO_RDATA(io_rdata),
    .IO_RVALID(io_rvalid), .JOY_CS(cs[4]), .MIDI_CS(cs[3]),
    .CD_CS0(cs[2]), .CD_CS1(cs[1]), .MODEM_CS(cs[0]), .PRESENT(present),
    .MIDI_IRQ(midi_irq), .CD_IRQ(cd_irq), .MODEM_IRQ(modem_irq));

  // Free-running 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (exp_q.size() != 0) failures = failures + 1;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.cfg(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({e, 14'h0000});
    host.cfg(1'b1, a, 8'h00);
  endtask
  // Pattern answer p is {valid, byte}
  task automatic io(input bit rw, input logic [11:0] a,
                    input logic [8:0] p, input logic [4:0] c);
    exp_q.push_back({8'h00, p, c});
    host.io(rw, a);
  endtask
  task automatic do_reset(input logic [2:0] s);
    rst_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  // Oldest note checked one cycle after each request; hang guard
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles > 4000) begin
      failures = failures + 1;
      end_of_test();
    end else begin
      if (pend) chk({cfg_rdata, io_rvalid, io_rdata, cs}, exp_q.pop_front());
      pend = cfg_rd || io_rd || io_wr;
    end
  end

  initial begin
    seed = 32'h9ad3600a;
    {failures, comparisons, cycles, pend} = 0;
    rst_n = 1'b0;
    strap = 3'b111;
    bases = '{12'h201, 12'h330, 12'h170, 12'h3e8};
    sizes = '{12'h001, 12'h002, 12'h008, 12'h008};
    @(posedge clk_sys);
    do_reset(3'b111);
    // Register set of device numbers 2 to 5
    for (i = 0; i < 4; i++) begin
      wr(8'h07, 8'h02 + 8'(i));
      rd(8'h30, 8'h00);
      wr(8'h30, 8'h01);
      rd(8'h30, 8'h01);
      wr(8'h60, {4'hf, bases[i][11:8]});
      wr(8'h61, bases[i][7:0]);
      rd(8'h60, {4'h0, bases[i][11:8]});
      rd(8'h61, bases[i][7:0]);
      r = 8'($random(seed));
      wr(8'h70, r);
      wr(8'h71, r);
      rd(8'h70, (i == 0) ? 8'h00 : r);
      if (i == 1) chk({14'h0, midi_irq}, {14'h0, r});
      if (i == 2) chk({14'h0, cd_irq}, {14'h0, r});
      rd(8'h71, (i == 0) ? 8'h00 : 8'h02);
      rd(8'h74, 8'h04);
      rd(8'h75, 8'h04);
    end
    chk({14'h0, modem_irq}, {14'h0, r});
    wr(8'h07, 8'h04);
    wr(8'h62, 8'h03);
    wr(8'h63, 8'h76);
    // Range edges of every decoder, reads and writes
    for (i = 0; i < 4; i++) begin
      exp_cs = (i == 3) ? 5'b00001 : 5'b10000 >> i;
      io(1'b1, bases[i], 9'h000, exp_cs);
      io(1'b0, bases[i] + sizes[i] - 1, 9'h000, exp_cs);
      io(1'b1, bases[i] + sizes[i], 9'h000, 5'h00);
    end
    io(1'b1, 12'h376, 9'h000, 5'b00010);
    io(1'b1, 12'h379, 9'h000, 5'b00010);
    io(1'b0, 12'h37a, 9'h000, 5'b00000);
    // Config reset, then range check on the inactive modem
    wr(8'h02, 8'h01);
    host.idle();
    repeat (6) @(posedge clk_sys);
    wr(8'h07, 8'h05);
    rd(8'h07, 8'h05);
    rd(8'h30, 8'h00);
    io(1'b1, bases[3], 9'h000, 5'h00);
    wr(8'h31, 8'h02);
    io(1'b1, bases[3], 9'h1aa, 5'h00);
    wr(8'h31, 8'h03);
    io(1'b1, bases[3] + 7, 9'h155, 5'h00);
    io(1'b0, bases[3], 9'h000, 5'h00);
    wr(8'h31, 8'h01);
    io(1'b1, bases[3], 9'h000, 5'h00);
    // Zero base keeps an active joystick off the bus
    wr(8'h07, 8'h02);
    wr(8'h30, 8'h01);
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h00);
    io(1'b1, 12'h000, 9'h000, 5'h00);
    // Uart folded into audio: cd moves to 3, modem to 4
    host.idle();
    do_reset(3'b110);
    chk({19'h0, present}, {19'h0, 3'b110});
    wr(8'h07, 8'h03);
    wr(8'h60, {4'h0, bases[2][11:8]});
    wr(8'h61, bases[2][7:0]);
    wr(8'h30, 8'h01);
    io(1'b1, bases[2], 9'h000, 5'b00100);
    wr(8'h07, 8'h04);
    rd(8'h71, 8'h02);
    wr(8'h07, 8'h05);
    rd(8'h74, 8'h00);
    host.idle();
    repeat (2) @(posedge clk_sys);
    end_of_test();
  end
endmodule

bind pld_top pld_monitor mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA), .IO_RD(IO_RD), .IO_WR(IO_WR),
  .IO_RVALID(IO_RVALID), .IO_RDATA(IO_RDATA), .JOY_CS(JOY_CS),
  .MIDI_CS(MIDI_CS), .CD_CS0(CD_CS0), .CD_CS1(CD_CS1),
  .MODEM_CS(MODEM_CS), .PRESENT(PRESENT));
